// ==== gpp_pkg.sv ====
// gpp_pkg: constants and carrier types of the gpio pin port block
// assumes apb word registers, byte address = 4 * register index
package gpp_pkg;
	localparam int unsigned GPP_PINS     = 8;
	localparam int unsigned GPP_AW       = 12;
	localparam logic [7:0]  GPP_RST_BYTE = 8'h00;
	localparam logic [7:0]  GPP_ASYNC    = 8'h44; // pins 2 and 6
	// register index inside one port block
	localparam logic [4:0] GPP_R_DIR    = 5'h00;
	localparam logic [4:0] GPP_R_DIRSET = 5'h01;
	localparam logic [4:0] GPP_R_DIRCLR = 5'h02;
	localparam logic [4:0] GPP_R_DIRTGL = 5'h03;
	localparam logic [4:0] GPP_R_OUT    = 5'h04;
	localparam logic [4:0] GPP_R_OUTSET = 5'h05;
	localparam logic [4:0] GPP_R_DRVCLR = 5'h06; // drive_clear_strobe
	localparam logic [4:0] GPP_R_OUTTGL = 5'h07;
	localparam logic [4:0] GPP_R_IN     = 5'h08;
	localparam logic [4:0] GPP_R_FLAGS  = 5'h09;
	localparam logic [4:0] GPP_R_MASK   = 5'h0a;
	localparam logic [1:0] GPP_R_CTRL_HI = 2'b10; // per_pad_control at 0x10 + n
	// index layout: port blocks at port*0x20, virtual ports at 0x60 + 4*port
	localparam int unsigned GPP_IDX_LSB  = 2;
	localparam int unsigned GPP_PORT_LSB = 5;
	localparam logic [5:0]  GPP_VPORT_TAG = 6'h06;
	localparam logic [2:0]  GPP_PBLK_TAG  = 3'h0;
	// per_pad_control fields
	localparam int unsigned GPP_CTL_INV  = 7;
	localparam int unsigned GPP_CTL_ALT  = 6;
	localparam int unsigned GPP_CTL_PULL = 3;

	// edge_sense_select codes
	typedef enum logic [2:0] {
		GPP_SENSE_INTOFF,
		GPP_SENSE_BOTH,
		GPP_SENSE_RISE,
		GPP_SENSE_FALL,
		GPP_SENSE_INPUT_OFF,
		GPP_SENSE_LOW
	} gpp_sense_t;

	typedef struct packed {
		logic [7:0]      dir;
		logic [7:0]      out;
		logic [7:0]      sync1;
		logic [7:0]      sync2;
		logic [7:0]      raw_q;
		logic [7:0]      prev;
		logic [7:0]      flags;
		logic [7:0]      mask;
		logic [7:0][7:0] ctrl;
	} gpp_port_t;

	typedef struct packed {
		logic       hit;
		logic [1:0] port;
		logic [4:0] regn;
	} gpp_dec_t;
endpackage

// ==== gpio_pin_port.sv ====
// gpio_pin_port: gpio ports behind an apb slave, with pin sense and interrupt
// assumes pad inputs synchronous enough to sample; pads resolved outside
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns

module gpp_gpio_pin_port
	import gpp_pkg::*;
#(
	parameter int unsigned PORTS = 3
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [GPP_AW-1:0]          paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            irq,
	output logic                            wake_req,
	input  wire logic [PORTS-1:0][7:0]      pad_in,
	output logic      [PORTS-1:0][7:0]      pad_out,
	output logic      [PORTS-1:0][7:0]      pad_oe,
	output logic      [PORTS-1:0][7:0]      pad_pullup,
	output logic      [PORTS-1:0][7:0]      pin_event,
	input  wire logic [PORTS-1:0][7:0]      alt_out,
	input  wire logic [PORTS-1:0][7:0]      alt_oe,
	output logic      [PORTS-1:0][7:0]      alt_in
);

	typedef struct packed {
		gpp_port_t [PORTS-1:0]  port;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
		logic                   irq;
		logic                   wake;
		logic [PORTS-1:0][7:0]  pad_out;
		logic [PORTS-1:0][7:0]  pad_oe;
		logic [PORTS-1:0][7:0]  pad_pull;
		logic [PORTS-1:0][7:0]  evt;
		logic [PORTS-1:0][7:0]  alt_in;
	} gpp_state_t;

	gpp_state_t state_reg;
	gpp_state_t state_next;
	gpp_dec_t   dec;
	logic       setup;
	logic       acc_wr;

	// refuse port counts the address map cannot hold; a fourth block would sit under the aliases
	generate
		if (PORTS < 1 || PORTS > 3) begin : g_bad_ports
			$error("PORTS must be 1 to 3");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// address decode: virtual aliases first, then port blocks
	function automatic gpp_dec_t gpp_decode(input logic [GPP_AW-1:0] a);
		logic [9:0] idx;
		gpp_dec_t   d;
		idx = a[GPP_AW-1:GPP_IDX_LSB];
		d = '0;
		if (idx[9:4] == GPP_VPORT_TAG) begin
			d.hit = 1'b1;
			d.port = idx[3:2];
			case (idx[1:0])
				2'd0:    d.regn = GPP_R_DIR;
				2'd1:    d.regn = GPP_R_OUT;
				2'd2:    d.regn = GPP_R_IN;
				default: d.regn = GPP_R_FLAGS;
			endcase
		end else if (idx[9:7] == GPP_PBLK_TAG) begin
			d.port = idx[6:5];
			d.regn = idx[4:0];
			d.hit = (d.regn <= GPP_R_MASK) || (d.regn[4:3] == GPP_R_CTRL_HI);
		end
		d.hit = d.hit && (32'(d.port) < PORTS);
		return d;
	endfunction

	function automatic logic gpp_sense_hit(input logic [2:0] cfg, input logic cur,
			input logic prv);
		logic h;
		case (gpp_sense_t'(cfg))
			GPP_SENSE_BOTH: h = cur ^ prv;
			GPP_SENSE_RISE: h = cur & ~prv;
			GPP_SENSE_FALL: h = ~cur & prv;
			GPP_SENSE_LOW:  h = ~cur;
			default:        h = 1'b0;
		endcase
		return h;
	endfunction

	function automatic logic [7:0] gpp_rmw(input logic [7:0] old, input logic [1:0] op,
			input logic [7:0] w);
		logic [7:0] r;
		case (op)
			2'd1:    r = old | w;
			2'd2:    r = old & ~w; // zero bits keep value
			2'd3:    r = old ^ w;
			default: r = w;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state: bus slave, pin sampling, sensing, pads
	always_comb begin
		gpp_port_t  ps;
		logic [7:0] inv;
		logic [7:0] in_val;
		logic [7:0] clr;
		logic       cur;
		logic       off;
		ps = '0;
		inv = 8'h00;
		in_val = 8'h00;
		clr = 8'h00;
		cur = 1'b0;
		off = 1'b0;
		state_next = state_reg;
		dec = gpp_decode(paddr);
		setup = psel & ~penable;
		// write lands on the access edge where pready is seen high
		acc_wr = psel & penable & state_reg.pready & pwrite & dec.hit;
		state_next.pready = setup;
		state_next.pslverr = setup & ~dec.hit;
		state_next.irq = 1'b0;
		state_next.wake = 1'b0;
		if (setup) begin
			state_next.prdata = 32'h0;
		end
		for (int p = 0; p < PORTS; p++) begin
			ps = state_reg.port[p];
			for (int n = 0; n < GPP_PINS; n++) begin
				inv[n] = ps.ctrl[n][GPP_CTL_INV];
			end
			// level read from pad in any direction, inversion
			in_val = ps.sync2 ^ inv;
			clr = 8'h00;
			for (int n = 0; n < GPP_PINS; n++) begin
				off = (ps.ctrl[n][2:0] == GPP_SENSE_INPUT_OFF);
				// two-flop synchroniser, frozen while sensing off
				state_next.port[p].sync1[n] = off ? ps.sync1[n] : pad_in[p][n];
				state_next.port[p].sync2[n] = off ? ps.sync2[n] : ps.sync1[n];
				state_next.port[p].raw_q[n] = pad_in[p][n];
				// pins 2 and 6 sense ahead of the synchroniser
				cur = (GPP_ASYNC[n] ? ps.raw_q[n] : ps.sync2[n]) ^ inv[n];
				state_next.port[p].prev[n] = cur;
				state_next.evt[p][n] = gpp_sense_hit(ps.ctrl[n][2:0], cur, ps.prev[n]);
				// direction drives pad unless shared function owns it
				if (ps.ctrl[n][GPP_CTL_ALT]) begin
					state_next.pad_out[p][n] = alt_out[p][n];
					state_next.pad_oe[p][n] = alt_oe[p][n];
				end else begin
					state_next.pad_out[p][n] = ps.out[n] ^ inv[n];
					state_next.pad_oe[p][n] = ps.dir[n];
				end
				state_next.pad_pull[p][n] = ps.ctrl[n][GPP_CTL_PULL];
			end
			state_next.alt_in[p] = in_val;
			// read data is latched in setup and shown in the access cycle
			if (setup && !pwrite && dec.hit && 32'(dec.port) == p) begin
				case (dec.regn)
					GPP_R_DIR, GPP_R_DIRSET, GPP_R_DIRCLR, GPP_R_DIRTGL:
						state_next.prdata[7:0] = ps.dir;
					// clear strobe reads back drive level
					GPP_R_OUT, GPP_R_OUTSET, GPP_R_DRVCLR, GPP_R_OUTTGL:
						state_next.prdata[7:0] = ps.out;
					GPP_R_IN:    state_next.prdata[7:0] = in_val;
					GPP_R_FLAGS: state_next.prdata[7:0] = ps.flags;
					GPP_R_MASK:  state_next.prdata[7:0] = ps.mask;
					default:     state_next.prdata[7:0] = ps.ctrl[dec.regn[2:0]];
				endcase
			end
			if (acc_wr && 32'(dec.port) == p) begin
				case (dec.regn)
					GPP_R_DIR, GPP_R_DIRSET, GPP_R_DIRCLR, GPP_R_DIRTGL:
						state_next.port[p].dir = gpp_rmw(ps.dir, dec.regn[1:0], pwdata[7:0]);
					GPP_R_OUT, GPP_R_OUTSET, GPP_R_DRVCLR, GPP_R_OUTTGL:
						state_next.port[p].out = gpp_rmw(ps.out, dec.regn[1:0], pwdata[7:0]);
					GPP_R_IN:    state_next.port[p].out = ps.out ^ pwdata[7:0];
					GPP_R_FLAGS: clr = pwdata[7:0];
					GPP_R_MASK:  state_next.port[p].mask = pwdata[7:0];
					default:     state_next.port[p].ctrl[dec.regn[2:0]] = pwdata[7:0];
				endcase
			end
			// sticky flags, a new event beats a same-cycle clear
			state_next.port[p].flags = (ps.flags & ~clr) | state_next.evt[p];
			state_next.irq = state_next.irq | (|(ps.flags & ps.mask));
			// async pin events raise wake straight from the raw capture
			state_next.wake = state_next.wake | (|(state_next.evt[p] & GPP_ASYNC));
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign prdata     = state_reg.prdata;
	assign pready     = state_reg.pready;
	assign pslverr    = state_reg.pslverr;
	assign irq        = state_reg.irq;
	assign wake_req   = state_reg.wake;
	assign pad_out    = state_reg.pad_out;
	assign pad_oe     = state_reg.pad_oe;
	assign pad_pullup = state_reg.pad_pull;
	assign pin_event  = state_reg.evt;
	assign alt_in     = state_reg.alt_in;

	////////////////////////////////////////////////////////////////////////
	// checks on port 0 pins 0 and 2 and port 0 registers
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic       clr_wr0;
	logic       set_dir0;
	logic       rd_clr0;
	logic       sense_on00;
	logic [2:0] cfg00;
	logic [2:0] cfg02;
	assign clr_wr0  = acc_wr && dec.port == 2'd0 && dec.regn == GPP_R_DRVCLR;
	assign set_dir0 = acc_wr && dec.port == 2'd0 && dec.regn == GPP_R_DIRSET;
	assign rd_clr0  = setup && !pwrite && dec.hit && dec.port == 2'd0
		&& dec.regn == GPP_R_DRVCLR;
	assign cfg00 = state_reg.port[0].ctrl[0][2:0];
	assign sense_on00 = cfg00 != GPP_SENSE_INPUT_OFF;
	assign cfg02 = state_reg.port[0].ctrl[2][2:0];

	sequence s_pin_steady;
		($stable(pad_in[0][0]) && sense_on00)[*3];
	endsequence

	AST_CLR_ZEROES: assert property (clr_wr0 |=>
		(state_reg.port[0].out & $past(pwdata[7:0])) == 8'h00)
		else $error("clear strobe left a drive bit set");
	AST_CLR_KEEPS: assert property (clr_wr0 |=>
		(state_reg.port[0].out & ~$past(pwdata[7:0]))
		== ($past(state_reg.port[0].out) & ~$past(pwdata[7:0])))
		else $error("clear strobe changed an unselected bit");
	AST_CLR_READ: assert property (rd_clr0 |=>
		prdata[7:0] == $past(state_reg.port[0].out) && pready)
		else $error("clear strobe read is not the drive level");
	AST_DIR_ONE: assert property (set_dir0 |=>
		(state_reg.port[0].dir & ~$past(pwdata[7:0]))
		== ($past(state_reg.port[0].dir) & ~$past(pwdata[7:0])))
		else $error("direction set disturbed other pins");
	AST_OE_DIR: assert property (!state_reg.port[0].ctrl[0][GPP_CTL_ALT] |=>
		pad_oe[0][0] == $past(state_reg.port[0].dir[0]))
		else $error("pad enable does not follow direction");
	AST_SYNC: assert property (s_pin_steady |->
		state_reg.port[0].sync2[0] == pad_in[0][0])
		else $error("input synchroniser did not settle in two cycles");
	AST_SYNC_OFF: assert property (!sense_on00 |=>
		$stable(state_reg.port[0].sync2[0]))
		else $error("synchroniser moved while sensing off");
	AST_RISE_FLAG: assert property (cfg00 == GPP_SENSE_RISE
		&& state_reg.port[0].sync2[0] == ~state_reg.port[0].ctrl[0][GPP_CTL_INV]
		&& !state_reg.port[0].prev[0] |=> state_reg.port[0].flags[0] && pin_event[0][0])
		else $error("rising edge did not set its flag");
	AST_PULL: assert property (1'b1 |=>
		pad_pullup[0][0] == $past(state_reg.port[0].ctrl[0][GPP_CTL_PULL]))
		else $error("pull-up does not follow pin control");
	AST_IRQ: assert property (|(state_reg.port[0].flags & state_reg.port[0].mask) |=>
		irq)
		else $error("unmasked flag without interrupt");
	// raw capture wakes one edge on
	AST_WAKE_FAST: assert property (cfg02 == GPP_SENSE_BOTH
		&& (state_reg.port[0].raw_q[2] ^ state_reg.port[0].ctrl[2][GPP_CTL_INV])
		!= state_reg.port[0].prev[2] |=> wake_req)
		else $error("async pin change gave no wake pulse");

endmodule

// ==== gpp_board_model.sv ====
// gpp_board_model: board side of the pads, one outside driver per pin
// assumes every pin has a weak board pull-down; the bench sets the drivers
`timescale 1ns/1ns
module gpp_board_model
	import gpp_pkg::*;
#(
	parameter int unsigned PORTS = 3
) (
	input  wire logic [PORTS-1:0][7:0] pad_out,
	input  wire logic [PORTS-1:0][7:0] pad_oe,
	input  wire logic [PORTS-1:0][7:0] pad_pullup,
	input  wire logic [PORTS-1:0][7:0] ext_drv,
	input  wire logic [PORTS-1:0][7:0] ext_en,
	output logic      [PORTS-1:0][7:0] pad_in
);
	// chip driver first, then outside driver, then pull-up; the pull-down
	// stops a released pin from keeping its last level
	always_comb begin
		for (int p = 0; p < PORTS; p++) begin
			pad_in[p] = (pad_oe[p] & pad_out[p]) | (~pad_oe[p] & ext_en[p] & ext_drv[p])
				| (~pad_oe[p] & ~ext_en[p] & pad_pullup[p]);
		end
	end
endmodule

// ==== tb.sv ====
// tb: register level tests of the three-port pin block over apb
// assumes zero wait states allowed but not relied on; board model on the pads
`timescale 1ns/1ns
module tb;
	import gpp_pkg::*;
	logic                  core_clk, rst, psel, penable, pwrite;
	logic [GPP_AW-1:0]     paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic                  pready, pslverr, irq, wake_req, err;
	logic [2:0][7:0]       pad_in, pad_out, pad_oe, pad_pullup, pin_event;
	logic [2:0][7:0]       alt_out, alt_oe, alt_in, ext_drv, ext_en;
	int                    miscompares = 0;
	int                    n_checks = 0;
	int                    cyc = 0;
	int                    n_wake = 0;
	int                    n_evt = 0;

	gpp_gpio_pin_port #(.PORTS(3)) i_dut (.core_clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .wake_req, .pad_in, .pad_out,
		.pad_oe, .pad_pullup, .pin_event, .alt_out, .alt_oe, .alt_in);
	gpp_board_model #(.PORTS(3)) i_board (.pad_out, .pad_oe, .pad_pullup, .ext_drv,
		.ext_en, .pad_in);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; request held until pready is seen at a rising edge,
	// and read data and error are taken at that same edge
	task automatic apb(input logic is_wr, input logic [9:0] idx, input logic [7:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdc(input string nm, input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(nm, rd[7:0], exp);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// wake and edge-sensed pin events are one-cycle pulses, so count them as they pass
	always @(posedge core_clk) begin
		if (wake_req === 1'b1)
			n_wake <= n_wake + 1;
		if (pin_event[1][3] === 1'b1)
			n_evt <= n_evt + 1;
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = '0;
		pwdata = '0;
		{alt_out, alt_oe, ext_drv, ext_en} = '0;
		fork
			// hang guard, far above the few hundred cycles the tests need
			begin
				while (cyc < 20000) begin
					@(posedge core_clk);
					cyc++;
				end
				miscompares++;
			end
			begin
				repeat (20) @(posedge core_clk);
				rst <= 1'b0;
				// port a: reset values, drive, read back through the synchroniser
				rdc("clear strobe reset", 10'h006, 8'h00);
				wr(10'h000, 8'hff);
				wr(10'h004, 8'ha5);
				repeat (2) @(posedge core_clk);
				chk("pad drive", pad_out[0], 8'ha5);
				chk("pad enable", pad_oe[0], 8'hff);
				repeat (3) @(posedge core_clk);
				rdc("input of output pins", 10'h008, 8'ha5);
				wr(10'h006, 8'h0f);
				rdc("drive after clear", 10'h004, 8'ha0);
				rdc("clear strobe read", 10'h006, 8'ha0);
				wr(10'h005, 8'h01);
				wr(10'h007, 8'h81);
				rdc("drive after set, toggle", 10'h004, 8'h20);
				wr(10'h002, 8'hf0);
				wr(10'h001, 8'h40);
				wr(10'h003, 8'h03);
				rdc("dir after clear, set, toggle", 10'h000, 8'h4c);
				// port a pin 0: rising sense, then its synchroniser frozen
				wr(10'h010, 8'h02);
				wr(10'h005, 8'h01);
				wr(10'h001, 8'h01);
				repeat (4) @(posedge core_clk);
				rdc("port a rise flag", 10'h009, 8'h01);
				rdc("port a flags via alias", 10'h063, 8'h01);
				wr(10'h010, 8'h04);
				// unmapped index is refused
				apb(1'b0, 10'h01f, 8'h00);
				chk("unmapped error", {7'h0, err}, 8'h01);
				chk("unmapped data", rd[7:0], 8'h00);
				// alias write reaches port c only
				wr(10'h069, 8'h3c);
				rdc("port c drive via alias", 10'h044, 8'h3c);
				rdc("port b drive untouched", 10'h024, 8'h00);
				// port b: frozen synchroniser on pin 0, sense codes on pin 3
				ext_en[1] <= 8'hff;
				wr(10'h030, 8'h04);
				ext_drv[1] <= 8'h01;
				repeat (5) @(posedge core_clk);
				rdc("frozen synchroniser", 10'h028, 8'h00);
				ext_drv[1] <= 8'h00;
				wr(10'h02a, 8'h08);
				for (logic [7:0] k = 8'h01; k < 8'h04; k++) begin
					wr(10'h033, k);
					wr(10'h029, 8'hff);
					ext_drv[1] <= 8'h08;
					repeat (6) @(posedge core_clk);
					rdc("rise flag", 10'h029, (k != 8'h03) ? 8'h08 : 8'h00);
					chk("irq on flag", {7'h0, irq}, (k != 8'h03) ? 8'h01 : 8'h00);
					wr(10'h029, 8'h08);
					ext_drv[1] <= 8'h00;
					repeat (6) @(posedge core_clk);
					rdc("fall flag", 10'h029, (k != 8'h02) ? 8'h08 : 8'h00);
					wr(10'h029, 8'h08);
				end
				repeat (2) @(posedge core_clk);
				chk("irq after clear", {7'h0, irq}, 8'h00);
				chk("pin event count", 8'(n_evt), 8'h04);
				wr(10'h033, 8'h05);
				repeat (4) @(posedge core_clk);
				rdc("low level flag", 10'h029, 8'h08);
				// port a pin 2 wakes on a change
				wr(10'h002, 8'h04);
				ext_en[0] <= 8'h04;
				wr(10'h012, 8'h01);
				ext_drv[0] <= 8'h04;
				repeat (5) @(posedge core_clk);
				chk("wake pulses", 8'(n_wake), 8'h01);
				// port c: pull-up on pin 4, shared function owns pin 7
				wr(10'h054, 8'h08);
				wr(10'h057, 8'h40);
				alt_oe[2] <= 8'h80;
				alt_out[2] <= 8'h80;
				repeat (5) @(posedge core_clk);
				chk("pull-up", pad_pullup[2], 8'h10);
				chk("shared enable", pad_oe[2], 8'h80);
				chk("shared drive", {7'h0, pad_out[2][7]}, 8'h01);
				chk("shared input", {7'h0, alt_in[2][7]}, 8'h01);
				rdc("port c input", 10'h048, 8'h90);
			end
		join_any
		stop_test();
	end
endmodule
